//--- rtl/gpio_port_map.svh
// Purpose: Register offsets, reset values and encodings of the I/O port.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one word per register.
// Notes:   Definitions only.
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define PORT_PIN_DATA_OFS       5'h00
`define PORT_PIN_DIRECTION_OFS  5'h04
`define PORT_PIN_OPTION_OFS     5'h08
`define EXT_IRQ_SENS_OFS        5'h0C
`define PIN_LEVEL_OFS           5'h10

`define PORT_RESET_VALUE        8'h00
`define SENS_RESET_VALUE        2'h0

`define SENS_LOW_LEVEL          2'h0
`define SENS_RISING             2'h1
`define SENS_FALLING            2'h2
`define SENS_BOTH_EDGES         2'h3

`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

//--- rtl/gpio_port_pkg.sv
// Purpose: Types shared by the I/O port design and its bench.
// Assumes: Constants live in gpio_port_map.svh.
// Notes:   Nothing here is imported; users write gpio_port_pkg::name.
package gpio_port_pkg;
   typedef logic [1:0] sens_t;
   typedef logic [1:0] axi_resp_t;
   typedef enum logic [2:0] {
      SEL_DATA,
      SEL_DIRECTION,
      SEL_OPTION,
      SEL_SENS,
      SEL_LEVEL,
      SEL_NONE
   } reg_sel_t;
endpackage

//--- rtl/bidirectional_io_port.sv
// Purpose: Eight-pin general-purpose I/O port with AXI4-Lite registers.
// Assumes: Peripheral alternate-function inputs come from logic on aclk.
// Notes:   Pins are split into input, output value and output enable.
//
// Operation
// - Eight pins, each set by same-numbered bits.
// - Input pin: data read returns pin level.
// - Input pin: data write changes latch only.
// - Output pin: latch drives, read returns latch.
// - Option picks push-pull or open-drain output.
// - Interrupt pin raises request on sensitivity event.
// - Shared vector: detected pin events are ORed.
// - Request latch hidden, cleared by fetch, sensitivity.
// - Enabled alternate function overrides direction, option.
// - Peripheral output forces output, peripheral drive style.
// - Input with alternate output: read returns it.
// - Output with alternate input: peripheral sees latch.
// - Modes: 00 float, 01 pull-up/irq, 10 od, 11 pp.
// - Irq pins: option enables interrupt, some pull-up.
// - Irq reaches CPU only unmasked and configured.
// - Wait, Halt keep state; interrupts wake device.
`include "gpio_port_map.svh"
`timescale 1ns/100ps
`default_nettype none

module bidirectional_io_port #(
   parameter int         WIDTH       = 8,
   parameter int         ADDR_W      = 5,
   parameter logic [7:0] IRQ_CAPABLE = 8'hFF,
   parameter logic [7:0] IRQ_PULLUP  = 8'h00
) (
   input  wire  logic              aclk,
   input  wire  logic              aresetn,
   input  wire  logic [ADDR_W-1:0] awaddr,
   input  wire  logic              awvalid,
   output logic                    awready,
   input  wire  logic [31:0]       wdata,
   input  wire  logic [3:0]        wstrb,
   input  wire  logic              wvalid,
   output logic                    wready,
   output gpio_port_pkg::axi_resp_t bresp,
   output logic                    bvalid,
   input  wire  logic              bready,
   input  wire  logic [ADDR_W-1:0] araddr,
   input  wire  logic              arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output gpio_port_pkg::axi_resp_t rresp,
   output logic                    rvalid,
   input  wire  logic              rready,
   input  wire  logic [WIDTH-1:0]  pin_in,
   output logic [WIDTH-1:0]        pin_out,
   output logic [WIDTH-1:0]        pin_oe,
   output logic [WIDTH-1:0]        pull_up_en,
   input  wire  logic [WIDTH-1:0]  af_out_en,
   input  wire  logic [WIDTH-1:0]  af_out_val,
   input  wire  logic [WIDTH-1:0]  af_open_drain,
   output logic [WIDTH-1:0]        af_in,
   input  wire  logic              vector_fetch,
   input  wire  logic              cpu_irq_masked,
   output logic                    irq_pending,
   output logic                    irq_to_cpu,
   output logic                    wake
);

   ////////////////////////////////////////////////////////////////////////////
   logic [WIDTH-1:0]     pin_data_latch;
   logic [WIDTH-1:0]     port_pin_direction;
   logic [WIDTH-1:0]     port_pin_option;
   gpio_port_pkg::sens_t ext_irq_sensitivity_reg;
   logic [WIDTH-1:0]     pin_meta;
   logic [WIDTH-1:0]     pin_sync;
   logic [WIDTH-1:0]     pin_prev;
   logic [ADDR_W-1:0]    aw_addr;
   logic                 aw_held;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic                 w_held;
   logic                 do_write;
   logic                 sens_write;
   logic [WIDTH-1:0]     eff_dir;
   logic [WIDTH-1:0]     eff_val;
   logic [WIDTH-1:0]     eff_od;
   logic [WIDTH-1:0]     data_view;
   logic [WIDTH-1:0]     irq_en;
   logic [WIDTH-1:0]     pin_event;
   logic                 event_any;
   gpio_port_pkg::reg_sel_t wsel;

   function automatic gpio_port_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
      case (a)
         `PORT_PIN_DATA_OFS:      decode = gpio_port_pkg::SEL_DATA;
         `PORT_PIN_DIRECTION_OFS: decode = gpio_port_pkg::SEL_DIRECTION;
         `PORT_PIN_OPTION_OFS:    decode = gpio_port_pkg::SEL_OPTION;
         `EXT_IRQ_SENS_OFS:       decode = gpio_port_pkg::SEL_SENS;
         `PIN_LEVEL_OFS:          decode = gpio_port_pkg::SEL_LEVEL;
         default:                 decode = gpio_port_pkg::SEL_NONE;
      endcase
   endfunction

   function automatic logic detect(input gpio_port_pkg::sens_t s,
                                   input logic cur, input logic prev);
      case (s)
         `SENS_LOW_LEVEL: detect = !cur;
         `SENS_RISING:    detect = cur && !prev;
         `SENS_FALLING:   detect = !cur && prev;
         default:         detect = cur != prev;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronizer; only pin_sync and its delayed copy pin_prev are read by logic.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order.
   assign do_write   = aw_held && w_held && !bvalid;
   assign wsel       = decode(aw_addr);
   assign sens_write = do_write && w_strb[0] && wsel == gpio_port_pkg::SEL_SENS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         awready <= 1'b0;
      end else begin
         awready <= !aw_held && !(awvalid && awready) && !bvalid;
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         wready <= 1'b0;
      end else begin
         wready <= !w_held && !(wvalid && wready) && !bvalid;
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `AXI_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= (wsel == gpio_port_pkg::SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Register writes; the latch is stored whatever the direction.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_data_latch          <= `PORT_RESET_VALUE;
         port_pin_direction      <= `PORT_RESET_VALUE;
         port_pin_option         <= `PORT_RESET_VALUE;
         ext_irq_sensitivity_reg <= `SENS_RESET_VALUE;
      end else if (do_write && w_strb[0]) begin
         case (wsel)
            gpio_port_pkg::SEL_DATA:      pin_data_latch <= w_data[WIDTH-1:0];
            gpio_port_pkg::SEL_DIRECTION: port_pin_direction <= w_data[WIDTH-1:0];
            gpio_port_pkg::SEL_OPTION:    port_pin_option <= w_data[WIDTH-1:0];
            gpio_port_pkg::SEL_SENS:      ext_irq_sensitivity_reg <= w_data[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel; the data register shows a per-pin view.
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (port_pin_direction[i])
            data_view[i] = pin_data_latch[i];
         else if (af_out_en[i])
            data_view[i] = af_out_val[i];
         else
            data_view[i] = pin_sync[i];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `AXI_RESP_OKAY;
      end else begin
         arready <= !rvalid && !(arvalid && arready);
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= `AXI_RESP_OKAY;
            rdata  <= '0;
            case (decode(araddr))
               gpio_port_pkg::SEL_DATA:      rdata[WIDTH-1:0] <= data_view;
               gpio_port_pkg::SEL_DIRECTION: rdata[WIDTH-1:0] <= port_pin_direction;
               gpio_port_pkg::SEL_OPTION:    rdata[WIDTH-1:0] <= port_pin_option;
               gpio_port_pkg::SEL_SENS:      rdata[1:0] <= ext_irq_sensitivity_reg;
               gpio_port_pkg::SEL_LEVEL:     rdata[WIDTH-1:0] <= pin_sync;
               default:                      rresp <= `AXI_RESP_SLVERR;
            endcase
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers; an active peripheral output replaces direction and option.
   assign eff_dir = port_pin_direction | af_out_en;
   assign eff_val = (af_out_en & af_out_val) | (~af_out_en & pin_data_latch);
   assign eff_od  = (af_out_en & af_open_drain) | (~af_out_en & ~port_pin_option);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pull_up_en <= '0;
         af_in      <= '0;
      end else begin
         pin_out    <= eff_val;
         pin_oe     <= eff_dir & (~eff_val | ~eff_od);
         pull_up_en <= ~eff_dir & port_pin_option & (~IRQ_CAPABLE | IRQ_PULLUP);
         af_in      <= (port_pin_direction & pin_data_latch)
                     | (~port_pin_direction & pin_sync);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // External interrupt: one vector for all interrupt-capable pins.
   assign irq_en = IRQ_CAPABLE & ~port_pin_direction & port_pin_option;

   always_comb begin
      for (int i = 0; i < WIDTH; i++)
         pin_event[i] = irq_en[i] && detect(ext_irq_sensitivity_reg, pin_sync[i],
                                            pin_prev[i]);
   end
   assign event_any = |pin_event;

   // A new event wins over a fetch or a sensitivity change.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_pending <= 1'b0;
         irq_to_cpu  <= 1'b0;
         wake        <= 1'b0;
      end else begin
         if (event_any)
            irq_pending <= 1'b1;
         else if (vector_fetch || sens_write)
            irq_pending <= 1'b0;
         irq_to_cpu <= irq_pending && !cpu_irq_masked;
         wake       <= irq_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_reset_float;
      @(posedge aclk) !aresetn |=> pin_oe == '0 && pull_up_en == '0;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("pin driven after reset");

   property p_od_high;
      @(posedge aclk) disable iff (!aresetn)
      (port_pin_direction[0] && !port_pin_option[0] && !af_out_en[0] && pin_data_latch[0])
      |=> !pin_oe[0];
   endproperty
   a_od_high: assert property (p_od_high) else $error("open-drain high driven");

   property p_pp_drive;
      @(posedge aclk) disable iff (!aresetn)
      (port_pin_direction[0] && port_pin_option[0] && !af_out_en[0])
      |=> pin_oe[0] && pin_out[0] == $past(pin_data_latch[0]);
   endproperty
   a_pp_drive: assert property (p_pp_drive) else $error("push-pull not latch");

   property p_input_free;
      @(posedge aclk) disable iff (!aresetn)
      (!port_pin_direction[1] && !af_out_en[1]) |=> !pin_oe[1];
   endproperty
   a_input_free: assert property (p_input_free) else $error("input pin driven");

   property p_af_force;
      @(posedge aclk) disable iff (!aresetn)
      (af_out_en[2] && !af_open_drain[2])
      |=> pin_oe[2] && pin_out[2] == $past(af_out_val[2]);
   endproperty
   a_af_force: assert property (p_af_force) else $error("peripheral output lost");

   property p_event_set;
      @(posedge aclk) disable iff (!aresetn)
      event_any |=> irq_pending ##1 wake;
   endproperty
   a_event_set: assert property (p_event_set) else $error("event not latched");

   property p_fetch_clear;
      @(posedge aclk) disable iff (!aresetn)
      ((vector_fetch || sens_write) && !event_any) |=> !irq_pending;
   endproperty
   a_fetch_clear: assert property (p_fetch_clear) else $error("request not cleared");

   property p_cpu_mask;
      @(posedge aclk) disable iff (!aresetn)
      irq_to_cpu |-> $past(irq_pending) && !$past(cpu_irq_masked);
   endproperty
   a_cpu_mask: assert property (p_cpu_mask) else $error("masked irq passed");

   property p_read_input;
      @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == `PORT_PIN_DATA_OFS && !port_pin_direction[3]
       && !af_out_en[3]) |=> rvalid && rdata[3] == $past(pin_sync[3]);
   endproperty
   a_read_input: assert property (p_read_input) else $error("input read wrong");

endmodule

`default_nettype wire

//--- tb/pin_world.sv
// Purpose: Model of the pads and board wiring around the I/O port.
// Assumes: Port drive wins over board drive, board drive over pull-up.
// Notes:   An undriven pin without pull-up toggles every cycle.
`timescale 1ns/100ps
`default_nettype none

module pin_world (
   input  wire logic       aclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pull_up_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic [7:0]      pin_in
);
   logic float_pat = 1'b0;

   always_ff @(posedge aclk) begin
      float_pat <= ~float_pat;
   end

   // A floating pin must never look like a stable level to the port.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                     pull_up_en[i] ? 1'b1 : float_pat;
      end
   end
endmodule
`default_nettype wire

//--- tb/bidirectional_io_port_tb_top.sv
// Purpose: Self-checking bench of the I/O port.
// Assumes: Four irq-capable pins, two of them with pull-up.
// Notes:   Bus answers are checked by a monitor against queued notes.
`include "gpio_port_map.svh"
`timescale 1ns/100ps
`default_nettype none

module bidirectional_io_port_tb_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq_pending, irq_to_cpu, wake;
   gpio_port_pkg::axi_resp_t bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] pin_in, pin_out, pin_oe, pull_up_en, af_in;
   logic [7:0] af_out_en = 8'h00, af_out_val = 8'h00, af_open_drain = 8'h00;
   logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
   logic vector_fetch = 1'b0, cpu_irq_masked = 1'b0;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   int err_count = 0, cmp_count = 0;
   logic [7:0] r, w, m, v;
   logic e;

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   bidirectional_io_port #(.IRQ_CAPABLE(8'h0F), .IRQ_PULLUP(8'h03)) i_bidirectional_io_port (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .af_out_en(af_out_en), .af_out_val(af_out_val), .af_open_drain(af_open_drain),
      .af_in(af_in), .vector_fetch(vector_fetch), .cpu_irq_masked(cpu_irq_masked),
      .irq_pending(irq_pending), .irq_to_cpu(irq_to_cpu), .wake(wake));

   pin_world i_pin_world (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up_en(pull_up_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // One transfer; the read side notes expected data, the monitor compares.
   task automatic bus(input bit wr, input logic [4:0] a, input logic [7:0] d,
                      input logic [1:0] resp);
      int n;
      bit done;
      n = 0;
      done = 1'b0;
      // One edge passes first, so a strobe the previous call dropped is not raised in that step.
      @(posedge aclk);
      if (wr) begin
         bq.push_back(resp);
         awaddr <= a;
         wdata <= {24'h000000, d};
         wstrb <= 4'h1;
         {awvalid, wvalid, bready} <= 3'h7;
      end else begin
         rq.push_back({resp, 24'h000000, d});
         araddr <= a;
         {arvalid, rready} <= 2'h3;
      end
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (bready && bvalid === 1'b1) begin
            bready <= 1'b0;
            done = 1'b1;
         end
         if (rready && rvalid === 1'b1) begin
            rready <= 1'b0;
            done = 1'b1;
         end
         n++;
         if (n > 50) begin
            err_count++;
            give_verdict();
         end
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, `AXI_RESP_OKAY);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] d);
      bus(1'b0, a, d, `AXI_RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (bready && bvalid === 1'b1) begin
         if (bq.size() == 0) check(32'h1, 32'h0);
         else check(bresp, bq.pop_front());
      end
      if (rready && rvalid === 1'b1) begin
         if (rq.size() == 0) check(32'h1, 32'h0);
         else begin
            check({rresp, rdata}, rq[0][33:0]);
            void'(rq.pop_front());
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(74688));
      wt(3);
      aresetn <= 1'b1;
      r = $urandom();
      w = $urandom();
      ext_val <= r;
      ext_en <= 8'hFF;
      wt(4);
      check(pin_oe, `PORT_RESET_VALUE);
      check(pull_up_en, 8'h00);
      rd(`PORT_PIN_DIRECTION_OFS, `PORT_RESET_VALUE);
      rd(`PORT_PIN_OPTION_OFS, `PORT_RESET_VALUE);
      rd(`EXT_IRQ_SENS_OFS, 8'h00);
      rd(`PORT_PIN_DATA_OFS, r);
      rd(`PIN_LEVEL_OFS, r);
      wr(`PORT_PIN_DATA_OFS, w);
      wt(3);
      check(pin_oe, 8'h00);
      rd(`PORT_PIN_DATA_OFS, r);
      $display("test input done");
      // The latch already holds w before the pins turn to output.
      ext_en <= 8'h00;
      wr(`PORT_PIN_DIRECTION_OFS, 8'hFF);
      wt(3);
      check(pin_oe, w ^ 8'hFF);
      check(af_in, w);
      rd(`PORT_PIN_DATA_OFS, w);
      wr(`PORT_PIN_OPTION_OFS, 8'hFF);
      wt(3);
      check(pin_oe, 8'hFF);
      check(pin_out, w);
      $display("test output done");
      wr(`PORT_PIN_OPTION_OFS, 8'h00);
      ext_en <= 8'h0C;
      wr(`PORT_PIN_DIRECTION_OFS, 8'h00);
      wr(`PORT_PIN_OPTION_OFS, 8'hFF);
      wt(4);
      check(pull_up_en, 8'hF3);
      rd(`PIN_LEVEL_OFS, (r & 8'h0C) | 8'hF3);
      wr(`PORT_PIN_OPTION_OFS, 8'h00);
      $display("test pull-up done");
      m = $urandom();
      v = $urandom();
      af_out_val <= v;
      af_out_en <= m;
      ext_en <= ~m;
      wt(4);
      check(pin_oe, m);
      check(pin_out, (v & m) | (w & ~m));
      rd(`PORT_PIN_DATA_OFS, (v & m) | (r & ~m));
      af_open_drain <= m;
      wt(3);
      check(pin_oe, m & ~v);
      af_out_en <= 8'h00;
      ext_en <= 8'hFF;
      $display("test alternate done");
      wr(`PORT_PIN_OPTION_OFS, 8'h0F);
      for (int s = 0; s < 4; s++) begin
         cpu_irq_masked <= s[0];
         ext_val <= 8'hFF;
         wt(4);
         wr(`EXT_IRQ_SENS_OFS, 8'(s));
         wt(4);
         check(irq_pending, 1'b0);
         ext_val <= 8'hDF;
         wt(5);
         check(irq_pending, 1'b0);
         ext_val <= ~(8'h01 << s);
         wt(5);
         e = (s != 1);
         check(irq_pending, e);
         check(irq_to_cpu, e & ~s[0]);
         check(wake, e);
         ext_val <= 8'hFF;
         wt(5);
         check(irq_pending, 1'b1);
         vector_fetch <= 1'b1;
         wt(1);
         vector_fetch <= 1'b0;
         wt(4);
         check(irq_pending, 1'b0);
      end
      ext_val <= 8'hFE;
      wt(5);
      check(irq_pending, 1'b1);
      wr(`EXT_IRQ_SENS_OFS, `SENS_FALLING);
      wt(3);
      check(irq_pending, 1'b0);
      $display("test interrupt done");
      bus(1'b1, 5'h14, 8'hA5, `AXI_RESP_SLVERR);
      bus(1'b0, 5'h14, 8'h00, `AXI_RESP_SLVERR);
      rd(`PORT_PIN_OPTION_OFS, 8'h0F);
      $display("test unmapped done");
      wt(2);
      give_verdict();
   end
endmodule
`default_nettype wire
